// ===== hw/plwdt_regs.svh
// Register map, field positions, service values and timing counts of the watchdog
`ifndef PLWDT_REGS_SVH
`define PLWDT_REGS_SVH

// Word indices; byte address is four times the index
`define PLW_IDX_OPT 22'h0000c0
`define PLW_IDX_SVC 22'h0fffab
`define PLW_IDX_STS 22'h000010
`define PLW_IDX_CLR 22'h000011
`define PLW_IDX_IEN 22'h000012
`define PLW_IDX_RSC 22'h000013

// Option byte fields
`define PLW_OPT_EN 4
`define PLW_OPT_SEL_HI 3
`define PLW_OPT_SEL_LO 1
`define PLW_OPT_STBY 0

// Service register values
`define PLW_KEY 8'hac
`define PLW_SVC_RD_OFF 8'h1a
`define PLW_SVC_RD_ON 8'h9a

// Interrupt status bits and reset cause bit
`define PLW_STS_ITV 0
`define PLW_STS_RES 1
`define PLW_RSC_WDT 4

// Overflow exponent per select code
`define PLW_EXP_0 5'd6
`define PLW_EXP_1 5'd7
`define PLW_EXP_2 5'd8
`define PLW_EXP_3 5'd9
`define PLW_EXP_4 5'd11
`define PLW_EXP_5 5'd13
`define PLW_EXP_6 5'd14
`define PLW_EXP_7 5'd16

// Slow oscillator rate against the 50 MHz system clock
`define PLW_CLK_HZ 50000000
`define PLW_FIL_HZ 17250
`define PLW_DIV (`PLW_CLK_HZ / `PLW_FIL_HZ)

`endif

// ===== hw/plwdt_pkg.sv
// Types shared by the watchdog design
package plwdt_pkg;

  typedef enum logic [2:0] {
    PH_CAPTURE,
    PH_IDLE,
    PH_RUN,
    PH_HOLD,
    PH_TRIPPED
  } plwdt_phase_e;

  typedef struct packed {
    logic count_enable_option;
    logic [2:0] overflow_select;
    logic standby_run_option;
  } plwdt_opt_s;

  typedef struct packed {
    logic [4:0] opt_s1;
    logic [4:0] opt_s2;
    plwdt_opt_s opt;
    plwdt_phase_e phase;
    logic [11:0] div;
    logic [16:0] cnt;
    logic stby_d;
    logic [1:0] sts;
    logic [1:0] ien;
    logic reset_cause_register;
    logic rst_req;
    logic ack;
    logic [31:0] dat;
    logic irq;
  } plwdt_state_s;

endpackage : plwdt_pkg

// ===== hw/plwdt_top.sv
// Program loop watchdog with a classic Wishbone register slave
//
// How it works
// R1: Count enable option starts counter after reset.
// R2: Option bits three to one select overflow.
// R3: Codes give 2^n-1 slow cycles overflow.
// R4: Standby run option decides counting in standby.
// R5: Halted counter restarts from zero after standby.
// R6: Enable 0 with standby run 1 prohibited.
// R7: Byte key write clears and restarts counter.
// R8: Wrong value written requests internal reset.
// R9: Bit-manipulation access requests internal reset.
// R10: Overflow without key write requests reset.
// R11: Service register reads 1AH or 9AH.
// R12: Interval interrupt at three quarters period.
// R13: Counting continues after interval interrupt.
// R14: Unused interval interrupt must be masked.
// R15: Restart may shorten next period one tick.
// R16: Key just before overflow still prevents reset.
// R17: Counter runs on slow oscillator ticks.
// R18: Watchdog reset sets reset cause bit four.
// R19: Option byte sampled at reset release only.
`timescale 1ns/100ps
`include "plwdt_regs.svh"

module plwdt_top #(
  parameter int LOCO_DIV = `PLW_DIV
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic por_i,
  input wire logic [4:0] opt_byte_i,
  input wire logic standby_i,
  input wire logic bitop_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [23:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic ack_o,
  output logic [31:0] dat_o,
  output logic irq_o,
  output logic wdt_rst_req_o
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (LOCO_DIV < 2 || LOCO_DIV > 4096) begin : g_bad_div
    $error("LOCO_DIV must lie in 2..4096");
  end

  localparam logic [11:0] DIV_LAST = 12'(LOCO_DIV - 1);

  plwdt_pkg::plwdt_state_s st_r;
  plwdt_pkg::plwdt_state_s st_nxt;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [4:0] exp_of(input logic [2:0] s);
    logic [4:0] e;
    e = `PLW_EXP_7;
    case (s)
      3'h0: e = `PLW_EXP_0;
      3'h1: e = `PLW_EXP_1;
      3'h2: e = `PLW_EXP_2;
      3'h3: e = `PLW_EXP_3;
      3'h4: e = `PLW_EXP_4;
      3'h5: e = `PLW_EXP_5;
      3'h6: e = `PLW_EXP_6;
      default: e = `PLW_EXP_7;
    endcase
    return e;
  endfunction : exp_of

  logic [4:0] ovf_exp;
  logic [16:0] ovf_lim;
  logic [16:0] itv_pt;
  logic [16:0] cnt_inc;
  logic tick;
  logic req;
  logic acc;
  logic [21:0] widx;
  logic svc_hit;
  logic svc_wr;
  logic key_ok;
  logic illegal;
  logic [7:0] svc_rd;

  always_comb begin
    ovf_exp = exp_of(st_r.opt.overflow_select); // [R2]
    ovf_lim = 17'((17'h1 << ovf_exp) - 17'h1); // [R3]
    itv_pt = 17'(17'h3 << (ovf_exp - 5'd2)); // [R12]
    cnt_inc = 17'(st_r.cnt + 17'h1);
    tick = (st_r.div == 12'h000); // [R17]
    req = cyc_i && stb_i;
    // Access lands on the edge that the master sees ack
    acc = req && st_r.ack;
    widx = adr_i[23:2];
    svc_hit = (widx == `PLW_IDX_SVC);
    svc_wr = acc && we_i && svc_hit;
    key_ok = svc_wr && (sel_i == 4'h1) && (dat_i[7:0] == `PLW_KEY) && !bitop_i; // [R7]
    illegal = (svc_wr && !key_ok) || (acc && svc_hit && bitop_i); // [R8] [R9]
    svc_rd = st_r.opt.count_enable_option ? `PLW_SVC_RD_ON : `PLW_SVC_RD_OFF; // [R11]
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_nxt = st_r;

    // Option byte pins are static but asynchronous to clk_i
    st_nxt.opt_s1 = opt_byte_i;
    st_nxt.opt_s2 = st_r.opt_s1;

    // Slow oscillator stands in as a free running tick
    st_nxt.div = tick ? DIV_LAST : 12'(st_r.div - 12'h001); // [R17]
    st_nxt.stby_d = standby_i;

    case (st_r.phase)
      plwdt_pkg::PH_CAPTURE: begin
        st_nxt.opt = plwdt_pkg::plwdt_opt_s'(st_r.opt_s2); // [R19]
        st_nxt.cnt = 17'h00000;
        st_nxt.phase = st_r.opt_s2[`PLW_OPT_EN] ? plwdt_pkg::PH_RUN
                                                : plwdt_pkg::PH_IDLE; // [R1]
      end
      plwdt_pkg::PH_IDLE: begin
        // Disabled counter never moves; the combination with
        // standby run set is not supported and is ignored here [R6]
        st_nxt.cnt = 17'h00000;
      end
      plwdt_pkg::PH_RUN: begin
        if (standby_i && !st_r.opt.standby_run_option) begin
          st_nxt.phase = plwdt_pkg::PH_HOLD; // [R4]
        end else if (tick) begin
          st_nxt.cnt = cnt_inc; // [R13]
          if (cnt_inc == itv_pt) begin
            st_nxt.sts[`PLW_STS_ITV] = 1'b1; // [R12]
          end
          if (cnt_inc == ovf_lim) begin
            st_nxt.phase = plwdt_pkg::PH_TRIPPED; // [R10]
            st_nxt.rst_req = 1'b1;
            st_nxt.reset_cause_register = 1'b1; // [R18]
          end
        end
      end
      plwdt_pkg::PH_HOLD: begin
        if (!standby_i) begin
          st_nxt.cnt = 17'h00000; // [R5]
          st_nxt.sts[`PLW_STS_RES] = 1'b1;
          st_nxt.phase = plwdt_pkg::PH_RUN;
        end
      end
      plwdt_pkg::PH_TRIPPED: begin
        st_nxt.rst_req = 1'b1;
      end
      default: begin
        st_nxt.phase = plwdt_pkg::PH_CAPTURE;
      end
    endcase

    // Key beats an overflow tick in the same cycle; divider is not
    // restarted, so the next period may be one tick short [R15] [R16]
    if (key_ok && st_r.phase == plwdt_pkg::PH_RUN && !(standby_i
        && !st_r.opt.standby_run_option)) begin
      st_nxt.cnt = 17'h00000; // [R7]
      st_nxt.phase = plwdt_pkg::PH_RUN;
      st_nxt.rst_req = 1'b0;
      st_nxt.reset_cause_register = st_r.reset_cause_register;
    end

    if (illegal) begin
      st_nxt.phase = plwdt_pkg::PH_TRIPPED; // [R8] [R9]
      st_nxt.rst_req = 1'b1;
      st_nxt.reset_cause_register = 1'b1; // [R18]
    end

    // ****************************************
    // Register writes; hardware set wins over clear
    // ****************************************
    if (acc && we_i && sel_i[0]) begin
      case (widx)
        `PLW_IDX_CLR: begin
          st_nxt.sts = st_nxt.sts & ~(dat_i[1:0] & ~(st_nxt.sts & ~st_r.sts));
        end
        `PLW_IDX_IEN: begin
          st_nxt.ien = dat_i[1:0]; // [R14]
        end
        `PLW_IDX_RSC: begin
          if (dat_i[`PLW_RSC_WDT] && !(st_nxt.reset_cause_register && !st_r.reset_cause_register)) begin
            st_nxt.reset_cause_register = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // ****************************************
    // Bus answer: one cycle ack, unmapped reads as zero
    // ****************************************
    st_nxt.ack = req && !st_r.ack;
    st_nxt.dat = 32'h00000000;
    if (req && !st_r.ack && !we_i) begin
      case (widx)
        `PLW_IDX_OPT: st_nxt.dat = {27'h0000000, st_r.opt};
        `PLW_IDX_SVC: st_nxt.dat = {24'h000000, svc_rd}; // [R11]
        `PLW_IDX_STS: st_nxt.dat = {30'h00000000, st_r.sts};
        `PLW_IDX_IEN: st_nxt.dat = {30'h00000000, st_r.ien};
        `PLW_IDX_RSC: st_nxt.dat = {27'h0000000, st_r.reset_cause_register, 4'h0}; // [R18]
        default: st_nxt.dat = 32'h00000000;
      endcase
    end

    st_nxt.irq = |(st_nxt.sts & st_nxt.ien); // [R14]

    // ****************************************
    // Synchronous reset; cause flag survives all but power-on
    // ****************************************
    if (rst_i) begin
      st_nxt.phase = plwdt_pkg::PH_CAPTURE;
      st_nxt.opt = '0;
      st_nxt.div = DIV_LAST;
      st_nxt.cnt = 17'h00000;
      st_nxt.stby_d = 1'b0;
      st_nxt.sts = 2'h0;
      st_nxt.ien = 2'h0;
      st_nxt.rst_req = 1'b0;
      st_nxt.ack = 1'b0;
      st_nxt.dat = 32'h00000000;
      st_nxt.irq = 1'b0;
      st_nxt.reset_cause_register = por_i ? 1'b0 : st_r.reset_cause_register; // [R18]
    end
  end

  always_ff @(posedge clk_i) begin
    st_r <= st_nxt;
  end

  assign ack_o = st_r.ack;
  assign dat_o = st_r.dat;
  assign irq_o = st_r.irq;
  assign wdt_rst_req_o = st_r.rst_req;

endmodule : plwdt_top

// ===== test/plwdt_sva.sv
// Port-level assertion checker for the watchdog
`timescale 1ns/100ps
`include "plwdt_regs.svh"
module plwdt_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [4:0] opt_byte_i,
  input wire logic bitop_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [23:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic ack_o,
  input wire logic [31:0] dat_o,
  input wire logic irq_o,
  input wire logic wdt_rst_req_o
);
  // ****
  // Checks
  // ****
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  wire logic svc = adr_i[23:2] == `PLW_IDX_SVC;
  sequence s_bad_wr;
    ack_o && we_i && svc && sel_i[0] && (dat_i[7:0] != `PLW_KEY || sel_i != 4'h1);
  endsequence
  sequence s_key_wr;
    ack_o && we_i && svc && sel_i == 4'h1 && !bitop_i && dat_i[7:0] == `PLW_KEY;
  endsequence
  chk_ack_once: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  chk_ack_reply: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered");
  chk_dat_idle: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data outside ack");
  chk_svc_read: assert property (ack_o && !we_i && svc |->
    dat_o == {24'h0, opt_byte_i[4] ? `PLW_SVC_RD_ON : `PLW_SVC_RD_OFF})
    else $error("service read value wrong");
  chk_bad_req: assert property (s_bad_wr |-> ##[0:2] wdt_rst_req_o)
    else $error("bad write without reset request");
  chk_bitop_req: assert property (ack_o && svc && bitop_i |-> ##[0:2] wdt_rst_req_o)
    else $error("bit access without reset request");
  chk_req_holds: assert property (wdt_rst_req_o |=> wdt_rst_req_o)
    else $error("reset request dropped");
  chk_key_saves: assert property (s_key_wr ##0 !wdt_rst_req_o |=> !wdt_rst_req_o [*8])
    else $error("reset request after key");
  chk_rel_quiet: assert property ($fell(rst_i) |-> !irq_o && !wdt_rst_req_o && !ack_o)
    else $error("outputs active at release");
endmodule : plwdt_sva
bind plwdt_top plwdt_sva u_plwdt_sva (.*);

// ===== test/test_plwdt_top.sv
// Self-checking bench for the watchdog
`timescale 1ns/100ps
`include "plwdt_regs.svh"
module test_plwdt_top;
  // ****
  // Bench
  // ****
  logic clk_i = 1'b0, rst_i = 1'b1, por_i = 1'b1, standby_i = 1'b0, bitop_i = 1'b0;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o, irq_o, wdt_rst_req_o;
  logic [4:0] opt_byte_i = 5'h10;
  logic [23:0] adr_i = 24'h0;
  logic [3:0] sel_i = 4'h1;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  int n_errors = 0, samples_checked = 0;
  // Small divider keeps the periods of codes 0 to 5 inside the run budget
  plwdt_top #(.LOCO_DIV(4)) u_plwdt_top (.*);
  initial forever #10 clk_i = ~clk_i;
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  task automatic bus(input logic w, input logic [21:0] idx, input logic [7:0] d,
                     input logic [3:0] s = 4'h1, input logic b = 1'b0);
    int t;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h0, d};
    sel_i <= s;
    bitop_i <= b;
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while (ack_o !== 1'b1 && t < 20);
    chk("ack", ack_o, 1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    bitop_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  task automatic rst(input logic [4:0] opt, input logic p);
    rst_i <= 1'b1;
    por_i <= p;
    opt_byte_i <= opt;
    standby_i <= 1'b0;
    tick(16);
    rst_i <= 1'b0;
    tick(2);
  endtask : rst
  task automatic t_regs;
    rst(5'h16, 1'b1);
    bus(0, `PLW_IDX_OPT, 0);
    chk("opt", rd, 32'h16);
    bus(1, `PLW_IDX_OPT, 0);
    bus(0, `PLW_IDX_OPT, 0);
    chk("opt kept", rd, 32'h16);
    bus(0, `PLW_IDX_SVC, 0);
    chk("svc on", rd, 32'h9a);
    bus(0, 22'h20, 0);
    chk("unmapped", rd, 32'h0);
    bus(0, `PLW_IDX_RSC, 0);
    chk("cause por", rd, 32'h0);
  endtask : t_regs
  task automatic t_off;
    rst(5'h00, 1'b0); // Enable 0 is never paired with standby run 1
    bus(0, `PLW_IDX_SVC, 0);
    chk("svc off", rd, 32'h1a);
    tick(300);
    chk("off req", wdt_rst_req_o, 0);
  endtask : t_off
  task automatic t_bad;
    logic [7:0] d[3] = '{8'h00, `PLW_KEY, `PLW_KEY};
    logic [3:0] s[3] = '{4'h1, 4'h1, 4'h3};
    for (int i = 0; i < 3; i++) begin
      rst(5'h10, 1'b0);
      bus(1, `PLW_IDX_SVC, d[i], s[i], i == 1);
      tick(2);
      chk("bad req", wdt_rst_req_o, 1);
    end
  endtask : t_bad
  task automatic t_key;
    rst(5'h10, 1'b0);
    // Each key after the first lands a few ticks before overflow
    repeat (4) begin
      bus(1, `PLW_IDX_SVC, `PLW_KEY);
      tick(240);
    end
    chk("kept alive", wdt_rst_req_o, 0);
  endtask : t_key
  task automatic t_stby;
    rst(5'h10, 1'b0);
    bus(1, `PLW_IDX_SVC, `PLW_KEY);
    tick(150);
    standby_i <= 1'b1;
    tick(300);
    chk("halted", wdt_rst_req_o, 0);
    standby_i <= 1'b0;
    tick(200);
    chk("restart zero", wdt_rst_req_o, 0);
    tick(80);
    chk("resume ovf", wdt_rst_req_o, 1);
    bus(0, `PLW_IDX_STS, 0);
    chk("resume sts", rd[1], 1);
    rst(5'h11, 1'b0);
    bus(1, `PLW_IDX_SVC, `PLW_KEY);
    standby_i <= 1'b1;
    tick(300);
    chk("stby runs", wdt_rst_req_o, 1);
  endtask : t_stby
  task automatic t_period;
    int e[6] = '{6, 7, 8, 9, 11, 13};
    int ti;
    int to;
    for (int c = 0; c < 6; c++) begin
      ti = 3 * (1 << e[c]);
      to = ((1 << e[c]) - 1) * 4;
      rst({1'b1, c[2:0], 1'b0}, 1'b0);
      bus(1, `PLW_IDX_IEN, c != 0); // First code runs masked
      bus(1, `PLW_IDX_SVC, `PLW_KEY);
      tick(ti - 10);
      chk("irq early", irq_o, 0);
      tick(20);
      chk("irq", irq_o, c != 0);
      tick(to - ti - 20);
      chk("ovf early", wdt_rst_req_o, 0);
      tick(20);
      chk("ovf", wdt_rst_req_o, 1);
      bus(1, `PLW_IDX_CLR, 8'h03);
      tick(2);
      chk("irq clr", irq_o, 0);
    end
    // Code 6 must outlive the code 5 period; its full period is beyond the run budget
    rst(5'h1c, 1'b0);
    bus(0, `PLW_IDX_OPT, 0);
    chk("opt c6", rd, 32'h1c);
    tick(33000);
    chk("c6 alive", wdt_rst_req_o, 0);
    rst(5'h10, 1'b0);
    bus(0, `PLW_IDX_RSC, 0);
    chk("cause", rd, 32'h10);
    bus(1, `PLW_IDX_RSC, 8'h10);
    bus(0, `PLW_IDX_RSC, 0);
    chk("cause clr", rd, 32'h0);
  endtask : t_period
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    tick(95000);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    t_regs();
    t_off();
    t_bad();
    t_key();
    t_stby();
    t_period();
    tally_and_finish();
  end
endmodule : test_plwdt_top
